// file: design/rgbpwm_pkg.sv
// Shared constants and types for the three-channel timer PWM block
package rgbpwm_pkg;

  // Channel count and bus widths
  localparam int unsigned NUM_CH = 3;
  localparam int unsigned ADDR_W = 8;

  // Register byte addresses
  localparam logic [7:0] ADDR_CNT_CTL = 8'h00;
  localparam logic [7:0] ADDR_RELOAD = 8'h04;
  localparam logic [7:0] ADDR_CUR_CNT = 8'h08;
  localparam logic [7:0] ADDR_CH_CTL_BASE = 8'h0C;
  localparam logic [7:0] ADDR_CH_CMP_BASE = 8'h10;
  localparam logic [7:0] ADDR_CH_STRIDE = 8'h08;
  localparam logic [7:0] ADDR_OUT_STAT = 8'h24;

  // Field positions in counter_control
  localparam int unsigned CTL_EN_BIT = 4;
  localparam int unsigned CTL_MODE_BIT = 3;
  localparam int unsigned CTL_UP_BIT = 2;
  localparam int unsigned CTL_PRE_LSB = 0;
  // Field positions in each channel control register
  localparam int unsigned CH_REST_BIT = 1;
  localparam int unsigned CH_MATCH_BIT = 0;
  // Field position of the enable copy in the output status register
  localparam int unsigned STAT_EN_BIT = 3;

  // Values after reset
  localparam logic [15:0] CNT_CTL_RST = 16'h0008;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] CH_CTL_RST = 16'h0000;
  localparam logic [15:0] CH_CMP_RST = 16'h0000;

  // Counter end points
  localparam logic [15:0] COUNT_MIN = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // Prescaler terminal counts for /1, /16, /64, /256
  localparam logic [7:0] PRE_TERM0 = 8'h00;
  localparam logic [7:0] PRE_TERM1 = 8'h0F;
  localparam logic [7:0] PRE_TERM2 = 8'h3F;
  localparam logic [7:0] PRE_TERM3 = 8'hFF;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Bus request signals from the master
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } rgbpwm_axi_req_t;

  // Bus answer signals to the master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rgbpwm_axi_rsp_t;

  // Per-channel settings handed to a channel
  typedef struct packed {
    logic rest_level;
    logic match_mode;
    logic [15:0] compare;
  } rgbpwm_chan_cfg_t;

  // Per-channel state
  typedef struct packed {
    logic active;
    logic pwm;
  } rgbpwm_chan_st_t;

  // Whole state of the top module
  typedef struct packed {
    logic [15:0] cnt_ctl;
    logic [15:0] reload;
    logic [NUM_CH-1:0][15:0] ch_ctl;
    logic [NUM_CH-1:0][15:0] ch_cmp;
    logic [15:0] count;
    logic [7:0] presc;
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rgbpwm_top_st_t;

  // Address of channel n control register
  function automatic logic [7:0] ch_ctl_addr(input int unsigned n);
    ch_ctl_addr = ADDR_CH_CTL_BASE + 8'(n) * ADDR_CH_STRIDE;
  endfunction

  // Address of channel n compare register
  function automatic logic [7:0] ch_cmp_addr(input int unsigned n);
    ch_cmp_addr = ADDR_CH_CMP_BASE + 8'(n) * ADDR_CH_STRIDE;
  endfunction

endpackage

// file: design/rgbpwm_chan.sv
// One PWM output channel driven by shared counter events
`timescale 1ns/1ps
module rgbpwm_chan (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire rgbpwm_pkg::rgbpwm_chan_cfg_t i_cfg,
  input wire logic i_run,
  input wire logic [15:0] i_count,
  input wire logic i_tick,
  input wire logic i_timeout,
  output logic o_pwm
);
  import rgbpwm_pkg::*;

  rgbpwm_chan_st_t st_q;
  rgbpwm_chan_st_t st_d;
  logic hit;

  // Compare hit only on a count step that is not a timeout
  // compare gated by mode
  assign hit = i_cfg.match_mode && i_tick && !i_timeout &&
               (i_count == i_cfg.compare);

  // Next state of the channel
  always_comb begin
    st_d = st_q;
    if (!i_run) begin
      st_d.active = 1'b0;
    end else if (!i_cfg.match_mode) begin
      if (i_timeout) begin
        st_d.active = !st_q.active;
      end
    end else if (i_timeout) begin
      st_d.active = 1'b0;
    end else if (hit) begin
      st_d.active = 1'b1;
    end
    st_d.pwm = i_cfg.rest_level ^ st_d.active;
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_pwm = st_q.pwm;

endmodule // rgbpwm_chan

// file: design/rgbpwm_top.sv
// Three-channel timer PWM block with counter and AXI4-Lite registers
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
// Functional notes
// - Control bit 1 of a channel gives the level its output rests at.
// - Control bit 0 of a channel picks toggle (0) or match (1) operation.
// - The compare value only matters while the channel is in match mode.
// - In match mode the output goes active when the count equals compare.
// - In match mode an active output returns to rest on a timeout.
// - A compare never reached, or hit with a timeout, leaves output rest.
// - Timeout is zero reached counting down or full scale counting up.
// - In periodic mode the counter reloads from the reload value.
module rgbpwm_top (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire rgbpwm_pkg::rgbpwm_axi_req_t i_axi_req,
  output rgbpwm_pkg::rgbpwm_axi_rsp_t o_axi_rsp,
  output logic [rgbpwm_pkg::NUM_CH-1:0] o_pwm
);
  import rgbpwm_pkg::*;

  rgbpwm_top_st_t st_q;
  rgbpwm_top_st_t st_d;
  rgbpwm_chan_cfg_t [NUM_CH-1:0] ch_cfg;
  logic run;
  logic periodic;
  logic count_up;
  logic tick;
  logic timeout;
  logic [7:0] pre_term;
  logic [15:0] start_val;

  // Byte-lane merge into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction

  // Whether a word address holds a register
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = ({a[7:2], 2'h0} <= ADDR_OUT_STAT);
  endfunction

  // Read value of the word at an address
  function automatic logic [31:0] read_word(input rgbpwm_top_st_t s,
                                            input logic [NUM_CH-1:0] pwm,
                                            input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'h0};
    read_word = 32'h0000_0000;
    if (w == ADDR_CNT_CTL) begin
      read_word[15:0] = s.cnt_ctl;
    end else if (w == ADDR_RELOAD) begin
      read_word[15:0] = s.reload;
    end else if (w == ADDR_CUR_CNT) begin
      read_word[15:0] = s.count;
    end else if (w == ADDR_OUT_STAT) begin
      read_word[NUM_CH-1:0] = pwm;
      read_word[STAT_EN_BIT] = s.cnt_ctl[CTL_EN_BIT];
    end
    for (int unsigned n = 0; n < NUM_CH; n++) begin
      if (w == ch_ctl_addr(n)) begin
        read_word[15:0] = s.ch_ctl[n];
      end
      if (w == ch_cmp_addr(n)) begin
        read_word[15:0] = s.ch_cmp[n];
      end
    end
  endfunction

  // Counter control fields
  assign run = st_q.cnt_ctl[CTL_EN_BIT];
  assign periodic = st_q.cnt_ctl[CTL_MODE_BIT];
  assign count_up = st_q.cnt_ctl[CTL_UP_BIT];

  // Prescaler terminal count from the divider select
  always_comb begin
    unique case (st_q.cnt_ctl[CTL_PRE_LSB +: 2])
      2'h0: pre_term = PRE_TERM0;
      2'h1: pre_term = PRE_TERM1;
      2'h2: pre_term = PRE_TERM2;
      2'h3: pre_term = PRE_TERM3;
    endcase
  end

  // Count step enable and timeout event
  assign tick = run && (st_q.presc == pre_term);
  assign timeout = tick && (st_q.count == (count_up ? COUNT_MAX : COUNT_MIN));

  // Value the counter starts from and returns to
  // periodic reload value
  assign start_val = periodic ? st_q.reload :
                     (count_up ? COUNT_MIN : COUNT_MAX);

  // Next state: counter, register writes and bus channels
  always_comb begin
    st_d = st_q;
    // Counter and prescaler
    if (!run) begin
      st_d.presc = 8'h00;
      st_d.count = start_val;
    end else if (tick) begin
      st_d.presc = 8'h00;
      if (timeout) begin
        st_d.count = start_val;
      end else if (count_up) begin
        st_d.count = st_q.count + 16'h0001;
      end else begin
        st_d.count = st_q.count - 16'h0001;
      end
    end else begin
      st_d.presc = st_q.presc + 8'h01;
    end
    // Write address and write data, taken in either order
    if (i_axi_req.awvalid && !st_q.aw_held) begin
      st_d.aw_held = 1'b1;
      st_d.awaddr = i_axi_req.awaddr;
    end
    if (i_axi_req.wvalid && !st_q.w_held) begin
      st_d.w_held = 1'b1;
      st_d.wdata = i_axi_req.wdata;
      st_d.wstrb = i_axi_req.wstrb;
    end
    // Perform the write once both halves are held
    if (st_q.aw_held && st_q.w_held && !st_q.bvalid) begin
      st_d.aw_held = 1'b0;
      st_d.w_held = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = addr_ok(st_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if ({st_q.awaddr[7:2], 2'h0} == ADDR_CNT_CTL) begin
        st_d.cnt_ctl = merge16(st_q.cnt_ctl, st_q.wdata, st_q.wstrb) &
                       16'h001F;
      end
      if ({st_q.awaddr[7:2], 2'h0} == ADDR_RELOAD) begin
        st_d.reload = merge16(st_q.reload, st_q.wdata, st_q.wstrb);
      end
      for (int unsigned n = 0; n < NUM_CH; n++) begin
        if ({st_q.awaddr[7:2], 2'h0} == ch_ctl_addr(n)) begin
          st_d.ch_ctl[n] = merge16(st_q.ch_ctl[n], st_q.wdata,
                                   st_q.wstrb) & 16'h0003;
        end
        if ({st_q.awaddr[7:2], 2'h0} == ch_cmp_addr(n)) begin
          st_d.ch_cmp[n] = merge16(st_q.ch_cmp[n], st_q.wdata, st_q.wstrb);
        end
      end
    end else if (st_q.bvalid && i_axi_req.bready) begin
      st_d.bvalid = 1'b0;
    end
    // Read channel
    if (i_axi_req.arvalid && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = read_word(st_q, o_pwm, i_axi_req.araddr);
      st_d.rresp = addr_ok(i_axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (st_q.rvalid && i_axi_req.rready) begin
      st_d.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= '0;
      st_q.cnt_ctl <= CNT_CTL_RST;
      st_q.reload <= RELOAD_RST;
      st_q.ch_ctl <= {NUM_CH{CH_CTL_RST}};
      st_q.ch_cmp <= {NUM_CH{CH_CMP_RST}};
      st_q.count <= COUNT_MAX;
    end else begin
      st_q <= st_d;
    end
  end

  // Bus answer signals
  always_comb begin
    o_axi_rsp.awready = !st_q.aw_held;
    o_axi_rsp.wready = !st_q.w_held;
    o_axi_rsp.bvalid = st_q.bvalid;
    o_axi_rsp.bresp = st_q.bresp;
    o_axi_rsp.arready = !st_q.rvalid;
    o_axi_rsp.rvalid = st_q.rvalid;
    o_axi_rsp.rdata = st_q.rdata;
    o_axi_rsp.rresp = st_q.rresp;
  end

  // Channels sharing the counter events
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    assign ch_cfg[g].rest_level = st_q.ch_ctl[g][CH_REST_BIT];
    assign ch_cfg[g].match_mode = st_q.ch_ctl[g][CH_MATCH_BIT];
    assign ch_cfg[g].compare = st_q.ch_cmp[g];

    rgbpwm_chan u_chan (
      .i_ref_clk (i_ref_clk),
      .i_rst_b (i_rst_b),
      .i_cfg (ch_cfg[g]),
      .i_run (run),
      .i_count (st_q.count),
      .i_tick (tick),
      .i_timeout (timeout),
      .o_pwm (o_pwm[g])
    );
  end

endmodule // rgbpwm_top

// file: testbench/rgbpwm_top_assertions.sv
// Concurrent checks on the ports of the PWM block
`timescale 1ns/1ps
module rgbpwm_top_assertions (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire rgbpwm_pkg::rgbpwm_axi_req_t i_axi_req,
  input wire rgbpwm_pkg::rgbpwm_axi_rsp_t o_axi_rsp,
  input wire logic [rgbpwm_pkg::NUM_CH-1:0] o_pwm
);
  import rgbpwm_pkg::*;
  // Shorthand for bus events
  wire ar_go = i_axi_req.arvalid && o_axi_rsp.arready;
  wire rv = o_axi_rsp.rvalid;
  wire bv = o_axi_rsp.bvalid;
  wire bad = i_axi_req.araddr[7:2] > 6'h09;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // Read answer timing and holding
  a_read_answer: assert property (ar_go |=> rv) else $error("no rvalid");
  a_read_hold: assert property (rv && !i_axi_req.rready |=>
    rv && $stable(o_axi_rsp.rdata)) else $error("rdata dropped");
  a_ar_refused: assert property (rv |-> !o_axi_rsp.arready)
    else $error("read taken while busy");
  // Write answer two edges after both halves
  a_write_answer: assert property (i_axi_req.awvalid && o_axi_rsp.awready
    && i_axi_req.wvalid && o_axi_rsp.wready |-> ##2 bv)
    else $error("no bvalid");
  a_write_hold: assert property (bv && !i_axi_req.bready |=>
    bv && $stable(o_axi_rsp.bresp)) else $error("bresp dropped");
  // Decode of mapped and unmapped reads, and outputs at rest after reset
  a_read_slverr: assert property (ar_go && bad |=>
    o_axi_rsp.rdata == 32'h0 && o_axi_rsp.rresp == RESP_SLVERR)
    else $error("unmapped read accepted");
  a_read_okay: assert property (ar_go && !bad |=> o_axi_rsp.rresp ==
    RESP_OKAY && o_axi_rsp.rdata[31:16] == 16'h0) else $error("bad read");
  a_rest_after_reset: assert property ($rose(i_rst_b) |->
    o_pwm == 3'h0) else $error("output not at rest");
endmodule // rgbpwm_top_assertions

bind rgbpwm_top rgbpwm_top_assertions rgbpwm_top_assertions_i (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_axi_req(i_axi_req),
  .o_axi_rsp(o_axi_rsp), .o_pwm(o_pwm));

// file: testbench/rgbpwm_led_model.sv
// Pin-side model of three LED drivers measuring run lengths
`timescale 1ns/1ps
module rgbpwm_led_model (
  input wire logic i_ref_clk,
  input wire logic i_clr,
  input wire logic [2:0] i_pwm,
  output logic [2:0][15:0] o_run_hi,
  output logic [2:0][15:0] o_run_lo,
  output logic [2:0] o_moved
);
  logic [2:0] prev;
  logic [2:0][15:0] cnt;
  // Close a run of cycles at each level change
  always @(posedge i_ref_clk) begin
    prev <= i_pwm;
    for (int n = 0; n < 3; n++) begin
      cnt[n] <= cnt[n] + 16'h1;
      if (i_clr) begin
        cnt[n] <= 16'h1;
        o_moved[n] <= 1'b0;
      end else if (i_pwm[n] !== prev[n]) begin
        cnt[n] <= 16'h1;
        o_moved[n] <= 1'b1;
        if (prev[n]) o_run_hi[n] <= cnt[n];
        else o_run_lo[n] <= cnt[n];
      end
    end
  end
endmodule // rgbpwm_led_model

// file: testbench/tb_rgbpwm_top.sv
// Self-checking bench for the three-channel PWM block
`timescale 1ns/1ps
module tb_rgbpwm_top;
  import rgbpwm_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic clr = 1'b0;
  // Late bready/rready and byte-lane strobes for corner cases
  logic slow = 1'b0;
  logic [3:0] strb = 4'hF;
  rgbpwm_axi_req_t req = '0;
  rgbpwm_axi_rsp_t rsp;
  logic [2:0] pwm, rest, moved;
  logic [2:0][15:0] hi, lo;
  logic [31:0] d;
  logic [15:0] r, c, p, a;
  logic [1:0] rs;
  int failures = 0;
  int tests_run = 0;
  rgbpwm_top rgbpwm_top_i (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_axi_req(req), .o_axi_rsp(rsp), .o_pwm(pwm));
  rgbpwm_led_model rgbpwm_led_model_i (.i_ref_clk(i_ref_clk),
    .i_clr(clr), .i_pwm(pwm), .o_run_hi(hi), .o_run_lo(lo),
    .o_moved(moved));
  // Clock of 25 ns
  always #12.5 i_ref_clk = ~i_ref_clk;
  task automatic check(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED %0t: %s", $time, m);
    end
  endtask
  // Write with address and data offered together
  task automatic wr(input logic [7:0] ad, input logic [31:0] dat);
    logic ta, tw, tb, bv;
    @(posedge i_ref_clk);
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.awaddr <= ad;
    req.wdata <= dat;
    req.wstrb <= strb;
    req.bready <= !slow;
    do begin
      @(negedge i_ref_clk);
      ta = req.awvalid && rsp.awready;
      tw = req.wvalid && rsp.wready;
      tb = req.bready && rsp.bvalid;
      bv = rsp.bvalid;
      rs = rsp.bresp;
      @(posedge i_ref_clk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (tb) req.bready <= 1'b0;
      else if (bv) req.bready <= 1'b1;
    end while (!tb);
  endtask
  // Read, then compare data and response
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e,
                        input logic [1:0] er);
    logic ta, tr, rv;
    @(posedge i_ref_clk);
    req.arvalid <= 1'b1;
    req.araddr <= ad;
    req.rready <= !slow;
    do begin
      @(negedge i_ref_clk);
      ta = req.arvalid && rsp.arready;
      tr = req.rready && rsp.rvalid;
      rv = rsp.rvalid;
      d = rsp.rdata;
      rs = rsp.rresp;
      @(posedge i_ref_clk);
      if (ta) req.arvalid <= 1'b0;
      if (tr) req.rready <= 1'b0;
      else if (rv) req.rready <= 1'b1;
    end while (!tr);
    check(d === e && rs === er, "read mismatch");
  endtask
  // Timeout period and active run of a channel
  function automatic logic [15:0] period(input logic u,
                                         input logic [15:0] v);
    return u ? 16'h0000 - v : v + 16'h0001;
  endfunction
  function automatic logic [15:0] act_len(input logic u,
                                          input logic [15:0] v);
    return u ? 16'hFFFF - v : v;
  endfunction
  task automatic complete_run();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #400000;
    failures++;
    complete_run();
  end
  initial begin
    void'($urandom(15020));
    repeat (3) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    // Reset values, field masking, unmapped place
    rd_chk(ADDR_CNT_CTL, {16'h0000, CNT_CTL_RST}, RESP_OKAY);
    rd_chk(ADDR_RELOAD, {16'h0000, RELOAD_RST}, RESP_OKAY);
    // Only the strobed byte lane lands
    strb = 4'h2;
    wr(ADDR_RELOAD, 32'h1234_5678);
    strb = 4'hF;
    rd_chk(ADDR_RELOAD, 32'h0000_5600, RESP_OKAY);
    // Free-running start values while stopped
    wr(ADDR_CNT_CTL, 32'h0);
    rd_chk(ADDR_CUR_CNT, {16'h0000, COUNT_MAX}, RESP_OKAY);
    wr(ADDR_CNT_CTL, 32'h4);
    rd_chk(ADDR_CUR_CNT, {16'h0000, COUNT_MIN}, RESP_OKAY);
    for (int k = 0; k < 6; k++) begin
      slow = k[1];
      rd_chk(8'h0C + 8'(4 * k), 32'h0, RESP_OKAY);
      d = $urandom;
      wr(8'h0C + 8'(4 * k), d);
      rd_chk(8'h0C + 8'(4 * k), d & (k[0] ? 32'hFFFF : 32'h3),
             RESP_OKAY);
    end
    wr(8'h28, $urandom);
    check(rs === RESP_SLVERR, "unmapped write");
    rd_chk(8'h28, 32'h0, RESP_SLVERR);
    // Toggle, match and idle channels: down, up, then down at /16
    for (int u = 0; u < 3; u++) begin
      r = 16'(20 + $urandom % 40);
      c = 16'(1 + $urandom % (r - 16'h1));
      if (u == 1) begin
        r = 16'hFFFF - r;
        c = r + 16'(1 + $urandom % (16'hFFFE - r));
      end
      p = period(u[0], r);
      a = act_len(u[0], c);
      if (u == 2) begin
        // Divide by 16 stretches every count step
        p = p * 16'h0010;
        a = a * 16'h0010;
      end
      rest = 3'($urandom);
      wr(ADDR_CNT_CTL, 32'h8);
      wr(ADDR_RELOAD, {16'h0, r});
      wr(8'h0C, {30'h0, rest[0], 1'b0});
      wr(8'h10, $urandom);
      wr(8'h14, {30'h0, rest[1], 1'b1});
      wr(8'h18, {16'h0, c});
      wr(8'h1C, {30'h0, rest[2], 1'b1});
      wr(8'h20, {16'h0, (u == 1) ? r - 16'h1 : 16'h0});
      @(negedge i_ref_clk);
      check(pwm === rest, "not at rest when stopped");
      rd_chk(ADDR_CUR_CNT, {16'h0000, r}, RESP_OKAY);
      rd_chk(ADDR_OUT_STAT, {28'h0000000, 1'b0, rest}, RESP_OKAY);
      clr <= 1'b1;
      wr(ADDR_CNT_CTL, (u == 1) ? 32'h1C : ((u == 2) ? 32'h19 : 32'h18));
      clr <= 1'b0;
      repeat (5 * p) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      check(hi[0] === p && lo[0] === p, "toggle");
      check((rest[1] ? lo[1] : hi[1]) === a, "active run");
      check((rest[1] ? hi[1] : lo[1]) === p - a, "rest run");
      check(moved[2] === 1'b0 && pwm[2] === rest[2], "idle");
    end
    // Reset in mid-run brings registers and outputs back to rest
    @(posedge i_ref_clk);
    i_rst_b <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    @(negedge i_ref_clk);
    check(pwm === 3'h0, "outputs after reset");
    rd_chk(ADDR_CNT_CTL, {16'h0000, CNT_CTL_RST}, RESP_OKAY);
    rd_chk(8'h14, {16'h0000, CH_CTL_RST}, RESP_OKAY);
    complete_run();
  end
endmodule // tb_rgbpwm_top
